// *** dpt_phy_timing_regs.sv ***
// Channel A PHY timing register bank with APB slave and mode selection.
// Assumes a synchronous APB master on pclk and a controller that flags idle.
//
// How it works
// R1: Each of eight lanes has a 4-bit power-management strobe delay code, 0..7 = -1..+3/4 clock.
// R2: The eight delay nibbles sit lane 0 lowest and each resets to 4, meaning no delay.
// R3: A 2-bit data/mask phase-range code selects nominal, quarter, half or three-quarter delay.
// R4: Lanes 0 and 1 keep separate power-management data/mask phase-range copies resetting to 0.
// R5: Lanes 0 and 1 have strobe phase-range fields, normal and power-management, resetting to 0.
// R6: Lanes 0 and 1 hold an 8-bit master DLL adjust with a power-management copy, both 0x78.
// R7: Lanes 0 and 1 each have a 6-bit master DLL test select that resets to zero.
// R8: The power-down bit powers down the lane master DLL and the reset bit holds it in reset.
// R9: A separate power-management DLL reset bit sits at bit 31 and bits 30:24 read zero.
// R10: Lanes 0 and 1 each hold an 8-bit read strobe phase with a power-management copy, both 0x24.
// R11: Lanes 0 and 1 each hold an 8-bit write data phase with a power-management copy, both 0x60.
// R12: Two miscellaneous words are plain 32-bit read-write registers resetting to zero.
// R13: Four spare words are plain 32-bit read-write registers resetting to zero.
// R14: The power-management copies apply while that mode is active, switching only when idle.
`timescale 1ns/1ps
module dpt_phy_timing_regs
	import dpt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	output logic pready,
	output logic [DATA_W-1:0] prdata,
	output logic pslverr,
	input wire logic pm_request,
	input wire logic ctrl_idle,
	output logic pm_active,
	output logic [NUM_LANE*DELAY_W-1:0] strobe_delay_pm,
	output logic [NUM_DLL_LANE*RANGE_W-1:0] data_phase_range,
	output logic [NUM_DLL_LANE*RANGE_W-1:0] strobe_phase_range,
	output logic [NUM_DLL_LANE*ADJ_W-1:0] master_adjust,
	output logic [NUM_DLL_LANE*TST_W-1:0] dll_test_select,
	output logic [NUM_DLL_LANE-1:0] dll_powerdown,
	output logic [NUM_DLL_LANE-1:0] dll_reset,
	output logic [NUM_DLL_LANE*PHASE_W-1:0] read_strobe_phase,
	output logic [NUM_DLL_LANE*PHASE_W-1:0] write_data_phase
);

	// ****************************************
	// Address decode
	// ****************************************
	logic [IDX_W-1:0] idx;
	logic aligned;
	logic [NUM_CFG-1:0] cfg_hit;
	logic [NUM_SPARE-1:0] spare_hit;
	logic any_cfg;
	logic any_spare;
	logic [SPARE_AW-1:0] spare_slot;
	logic [DATA_W-1:0] cfg_rd;

	// Only the low index bits carry an address; bits above them are ignored, so upper addresses alias
	assign idx = paddr[IDX_LSB +: IDX_W];
	assign aligned = (paddr[IDX_LSB-1:0] == '0);

	for (genvar i = 0; i < NUM_CFG; i++)
	begin : g_cfg_hit
		assign cfg_hit[i] = aligned && (idx == CFG_IDX[i]);
	end

	for (genvar i = 0; i < NUM_SPARE; i++)
	begin : g_spare_hit
		assign spare_hit[i] = aligned && (idx == SPARE_IDX[i]);
	end

	assign any_cfg = |cfg_hit;
	assign any_spare = |spare_hit;

	always_comb
	begin
		spare_slot = '0;
		for (int i = 0; i < NUM_SPARE; i++)
		begin
			if (spare_hit[i])
				spare_slot = SPARE_AW'(i);
		end
	end

	// ****************************************
	// APB handshake
	// ****************************************
	// Every access takes one wait state so that the spare store can answer
	// from its registered read port; this keeps the timing uniform for all words.
	logic ready_q;
	logic err_q;
	logic [DATA_W-1:0] rdata_q;
	logic wr_commit;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ready_q <= 1'b0;
		else if (pce)
			ready_q <= psel && penable && !ready_q;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			err_q <= 1'b0;
		else if (pce)
			err_q <= psel && penable && !ready_q && !any_cfg && !any_spare;
	end

	assign wr_commit = pce && psel && penable && ready_q && pwrite;
	assign pready = ready_q;
	assign pslverr = err_q;

	// ****************************************
	// Configuration words
	// ****************************************
	logic [DATA_W-1:0] cfg_q [NUM_CFG];

	for (genvar i = 0; i < NUM_CFG; i++)
	begin : g_cfg
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				cfg_q[i] <= CFG_RST[i]; // [R2] [R4] [R5] [R6] [R7] [R8] [R10] [R11]
			else if (wr_commit && cfg_hit[i])
				cfg_q[i] <= pwdata & CFG_MASK[i]; // [R9]
		end
	end

	always_comb
	begin
		cfg_rd = READ_UNMAPPED;
		for (int i = 0; i < NUM_CFG; i++)
		begin
			if (cfg_hit[i])
				cfg_rd = cfg_q[i];
		end
	end

	// ****************************************
	// Spare and miscellaneous words
	// ****************************************
	dpt_store_if st ();

	assign st.we = wr_commit && any_spare; // [R12] [R13]
	assign st.waddr = spare_slot;
	assign st.wdata = pwdata;
	assign st.raddr = spare_slot;

	dpt_spare_store u_store (
		.pclk(pclk),
		.presetn(presetn),
		.pce(pce),
		.st(st.store)
	);

	// ****************************************
	// Read data
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rdata_q <= READ_UNMAPPED;
		else if (pce && psel && penable && !ready_q)
		begin
			if (any_cfg)
				rdata_q <= cfg_rd;
			else if (any_spare)
				rdata_q <= st.rdata;
			else
				rdata_q <= READ_UNMAPPED;
		end
	end

	assign prdata = rdata_q;

	// ****************************************
	// Mode selection
	// ****************************************
	// Switching mid-burst would retune the DLLs under live traffic, so the
	// change waits for the controller to report idle.
	dpt_mode_e mode_q;
	dpt_mode_e mode_d;

	always_comb
	begin
		mode_d = mode_q;
		case (mode_q)
			DPT_NORMAL:
			begin
				if (pm_request && ctrl_idle)
					mode_d = DPT_POWER_MGMT; // [R14]
			end
			DPT_POWER_MGMT:
			begin
				if (!pm_request && ctrl_idle)
					mode_d = DPT_NORMAL; // [R14]
			end
			default:
				mode_d = DPT_NORMAL;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode_q <= DPT_NORMAL;
		else if (pce)
			mode_q <= mode_d;
	end

	assign pm_active = (mode_q == DPT_POWER_MGMT);

	// ****************************************
	// Lane settings to the PHY
	// ****************************************
	logic [DATA_W-1:0] delay_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			delay_q <= CFG_RST[SLOT_STROBE_DELAY];
		else if (pce)
			delay_q <= cfg_q[SLOT_STROBE_DELAY]; // [R1] [R2]
	end

	assign strobe_delay_pm = delay_q;

	logic [NUM_DLL_LANE*RANGE_W-1:0] drange_q;
	logic [NUM_DLL_LANE*RANGE_W-1:0] srange_q;
	logic [NUM_DLL_LANE*ADJ_W-1:0] adj_q;
	logic [NUM_DLL_LANE*TST_W-1:0] tst_q;
	logic [NUM_DLL_LANE-1:0] pwrdn_q;
	logic [NUM_DLL_LANE-1:0] rst_q;
	logic [NUM_DLL_LANE*PHASE_W-1:0] rphase_q;
	logic [NUM_DLL_LANE*PHASE_W-1:0] wphase_q;

	for (genvar l = 0; l < NUM_DLL_LANE; l++)
	begin : g_lane
		logic [DATA_W-1:0] mdll;
		logic [DATA_W-1:0] rph;
		logic [DATA_W-1:0] wph;
		logic pm;

		assign mdll = cfg_q[SLOT_MASTER_DLL+l];
		assign rph = cfg_q[SLOT_READ_PHASE+l];
		assign wph = cfg_q[SLOT_WRITE_PHASE+l];
		assign pm = (mode_q == DPT_POWER_MGMT);

		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				drange_q[l*RANGE_W +: RANGE_W] <= RANGE_NOMINAL_INV;
				srange_q[l*RANGE_W +: RANGE_W] <= RANGE_NOMINAL_INV;
			end
			else if (pce)
			begin
				// Same four-value code in both copies
				drange_q[l*RANGE_W +: RANGE_W] <= pm ? // [R3] [R4] [R14]
					cfg_q[SLOT_DATA_RANGE][RANGE_PM_LSB+l*RANGE_W +: RANGE_W] :
					cfg_q[SLOT_DATA_RANGE][l*RANGE_W +: RANGE_W];
				srange_q[l*RANGE_W +: RANGE_W] <= pm ? // [R5] [R14]
					cfg_q[SLOT_STROBE_RANGE][RANGE_PM_LSB+l*RANGE_W +: RANGE_W] :
					cfg_q[SLOT_STROBE_RANGE][l*RANGE_W +: RANGE_W];
			end
		end

		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				adj_q[l*ADJ_W +: ADJ_W] <= CFG_RST[SLOT_MASTER_DLL][ADJ_LSB +: ADJ_W];
				tst_q[l*TST_W +: TST_W] <= '0;
				pwrdn_q[l] <= 1'b0;
				rst_q[l] <= 1'b0;
			end
			else if (pce)
			begin
				adj_q[l*ADJ_W +: ADJ_W] <= pm ? mdll[ADJ_PM_LSB +: ADJ_W] : // [R6] [R14]
					mdll[ADJ_LSB +: ADJ_W];
				tst_q[l*TST_W +: TST_W] <= mdll[TST_LSB +: TST_W]; // [R7]
				pwrdn_q[l] <= mdll[PWRDN_BIT]; // [R8]
				rst_q[l] <= pm ? mdll[RST_PM_BIT] : mdll[RST_BIT]; // [R8] [R9] [R14]
			end
		end

		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				rphase_q[l*PHASE_W +: PHASE_W] <= CFG_RST[SLOT_READ_PHASE][PHASE_LSB +: PHASE_W];
				wphase_q[l*PHASE_W +: PHASE_W] <= CFG_RST[SLOT_WRITE_PHASE][PHASE_LSB +: PHASE_W];
			end
			else if (pce)
			begin
				rphase_q[l*PHASE_W +: PHASE_W] <= pm ? rph[PHASE_PM_LSB +: PHASE_W] : // [R10] [R14]
					rph[PHASE_LSB +: PHASE_W];
				wphase_q[l*PHASE_W +: PHASE_W] <= pm ? wph[PHASE_PM_LSB +: PHASE_W] : // [R11] [R14]
					wph[PHASE_LSB +: PHASE_W];
			end
		end
	end

	assign data_phase_range = drange_q;
	assign strobe_phase_range = srange_q;
	assign master_adjust = adj_q;
	assign dll_test_select = tst_q;
	assign dll_powerdown = pwrdn_q;
	assign dll_reset = rst_q;
	assign read_strobe_phase = rphase_q;
	assign write_data_phase = wphase_q;

endmodule : dpt_phy_timing_regs

// *** dpt_pkg.sv ***
// Constants for the channel A PHY timing register bank.
// Assumes the register index space is reached over APB as byte address = index * 4.
package dpt_pkg;

	// ****************************************
	// Bus geometry
	// ****************************************
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int IDX_W = 8;
	localparam int IDX_LSB = 2;
	localparam int NUM_CFG = 9;
	localparam int NUM_SPARE = 6;
	localparam int SPARE_AW = 3;
	localparam int NUM_LANE = 8;
	localparam int NUM_DLL_LANE = 2;

	// ****************************************
	// Register indices (byte address is four times the index)
	// ****************************************
	localparam logic [7:0] IDX_STROBE_OUT_DELAY_PM = 8'hD3;
	localparam logic [7:0] IDX_CHANNEL_MISC = 8'hD4;
	localparam logic [7:0] IDX_CHANNEL_MISC_SECOND = 8'hD5;
	localparam logic [7:0] IDX_DATA_PHASE_RANGE = 8'hD6;
	localparam logic [7:0] IDX_STROBE_PHASE_RANGE = 8'hD7;
	localparam logic [7:0] IDX_LANE0_MASTER_DLL = 8'hD8;
	localparam logic [7:0] IDX_LANE1_MASTER_DLL = 8'hD9;
	localparam logic [7:0] IDX_LANE0_READ_STROBE_PHASE = 8'hE0;
	localparam logic [7:0] IDX_LANE1_READ_STROBE_PHASE = 8'hE1;
	localparam logic [7:0] IDX_LANE0_WRITE_DATA_PHASE = 8'hE8;
	localparam logic [7:0] IDX_LANE1_WRITE_DATA_PHASE = 8'hE9;
	localparam logic [7:0] IDX_SPARE_WORD_0 = 8'hF0;
	localparam logic [7:0] IDX_SPARE_WORD_1 = 8'hF1;
	localparam logic [7:0] IDX_SPARE_WORD_2 = 8'hF2;
	localparam logic [7:0] IDX_SPARE_WORD_3 = 8'hF3;

	// Configuration words held in flops, in slot order
	localparam logic [7:0] CFG_IDX [NUM_CFG] = '{IDX_STROBE_OUT_DELAY_PM, IDX_DATA_PHASE_RANGE,
		IDX_STROBE_PHASE_RANGE, IDX_LANE0_MASTER_DLL, IDX_LANE1_MASTER_DLL,
		IDX_LANE0_READ_STROBE_PHASE, IDX_LANE1_READ_STROBE_PHASE,
		IDX_LANE0_WRITE_DATA_PHASE, IDX_LANE1_WRITE_DATA_PHASE};
	localparam logic [31:0] CFG_RST [NUM_CFG] = '{32'h44444444, 32'h00000000, 32'h00000000,
		32'h00780078, 32'h00780078, 32'h00240024, 32'h00240024, 32'h00600060, 32'h00600060};
	// Writable bits; reserved bits stay zero
	localparam logic [31:0] CFG_MASK [NUM_CFG] = '{32'hFFFFFFFF, 32'h000F000F, 32'h000F000F,
		32'h80FFFFFF, 32'h80FFFFFF, 32'h00FF00FF, 32'h00FF00FF, 32'h00FF00FF, 32'h00FF00FF};
	localparam int SLOT_STROBE_DELAY = 0;
	localparam int SLOT_DATA_RANGE = 1;
	localparam int SLOT_STROBE_RANGE = 2;
	localparam int SLOT_MASTER_DLL = 3;
	localparam int SLOT_READ_PHASE = 5;
	localparam int SLOT_WRITE_PHASE = 7;

	// Spare words kept in the small store, in slot order
	localparam logic [7:0] SPARE_IDX [NUM_SPARE] = '{IDX_CHANNEL_MISC, IDX_CHANNEL_MISC_SECOND,
		IDX_SPARE_WORD_0, IDX_SPARE_WORD_1, IDX_SPARE_WORD_2, IDX_SPARE_WORD_3};
	localparam logic [31:0] SPARE_RST = 32'h00000000;

	// ****************************************
	// Field layout
	// ****************************************
	localparam int DELAY_W = 4;
	localparam int RANGE_W = 2;
	localparam int RANGE_PM_LSB = 16;
	localparam int ADJ_W = 8;
	localparam int ADJ_LSB = 0;
	localparam int ADJ_PM_LSB = 16;
	localparam int TST_W = 6;
	localparam int TST_LSB = 8;
	localparam int PWRDN_BIT = 14;
	localparam int RST_BIT = 15;
	localparam int RST_PM_BIT = 31;
	localparam int PHASE_W = 8;
	localparam int PHASE_LSB = 0;
	localparam int PHASE_PM_LSB = 16;

	// Phase-range codes
	localparam logic [1:0] RANGE_NOMINAL_INV = 2'h0;
	localparam logic [1:0] RANGE_QUARTER = 2'h1;
	localparam logic [1:0] RANGE_HALF = 2'h2;
	localparam logic [1:0] RANGE_THREE_QUARTER_INV = 2'h3;

	localparam logic [31:0] READ_UNMAPPED = 32'h00000000;

	typedef enum logic [1:0] {
		DPT_NORMAL = 2'b01,
		DPT_POWER_MGMT = 2'b10
	} dpt_mode_e;

endpackage : dpt_pkg

// *** dpt_store_if.sv ***
// Port bundle between the register bank and its spare-word store.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface dpt_store_if;
	import dpt_pkg::*;
	logic we;
	logic [SPARE_AW-1:0] waddr;
	logic [DATA_W-1:0] wdata;
	logic [SPARE_AW-1:0] raddr;
	logic [DATA_W-1:0] rdata;
	modport bank (output we, output waddr, output wdata, output raddr, input rdata);
	modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : dpt_store_if

// *** dpt_spare_store.sv ***
// Small store for the reserved and miscellaneous words.
// Assumes pclk domain; read data are registered one cycle after raddr.
`timescale 1ns/1ps
module dpt_spare_store
	import dpt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	dpt_store_if.store st
);

	logic [DATA_W-1:0] mem_q [NUM_SPARE];
	logic [DATA_W-1:0] rdata_q;

	// ****************************************
	// Storage
	// ****************************************
	for (genvar i = 0; i < NUM_SPARE; i++)
	begin : g_word
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				mem_q[i] <= SPARE_RST; // [R12] [R13]
			else if (pce && st.we && (st.waddr == SPARE_AW'(i)))
				mem_q[i] <= st.wdata; // [R12] [R13]
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rdata_q <= SPARE_RST;
		else if (pce)
			rdata_q <= (st.raddr < SPARE_AW'(NUM_SPARE)) ? mem_q[st.raddr] : SPARE_RST;
	end

	assign st.rdata = rdata_q;

endmodule : dpt_spare_store

// *** dpt_phy_timing_regs_props.sv ***
// Port checker for the timing register bank.
// Assumes the checks pause while pce is low, since every flop is frozen then.
`timescale 1ns/1ps
module dpt_phy_timing_regs_props
	import dpt_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	input wire logic psel,
	input wire logic penable,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic pready,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic pslverr,
	input wire logic pm_request,
	input wire logic ctrl_idle,
	input wire logic pm_active,
	input wire logic [NUM_LANE*DELAY_W-1:0] strobe_delay_pm,
	input wire logic [NUM_DLL_LANE*ADJ_W-1:0] master_adjust
);
	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn || !pce);
	// *****
	// Bus phases
	// *****
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable;
	endsequence
	one_wait_a: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
		else $error("ready not in second access cycle");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	idle_quiet_a: assert property (!psel |=> !pready)
		else $error("ready without select");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	misalign_err_a: assert property (access_s ##0 pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access not refused");
	refused_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("refused read data not zero");
	reset_values_a: assert property ($rose(presetn) |->
		strobe_delay_pm == 32'h44444444 && master_adjust == 16'h7878)
		else $error("lane outputs not at reset values");
	pm_enter_a: assert property (pm_request && ctrl_idle && !pm_active |=> pm_active)
		else $error("mode not entered");
	pm_leave_a: assert property (!pm_request && ctrl_idle && pm_active |=> !pm_active)
		else $error("mode not left");
	busy_hold_a: assert property (!ctrl_idle |=> $stable(pm_active))
		else $error("mode switched while busy");
endmodule : dpt_phy_timing_regs_props

bind dpt_phy_timing_regs dpt_phy_timing_regs_props u_props (.pclk, .presetn, .pce, .psel,
	.penable, .paddr, .pready, .prdata, .pslverr, .pm_request, .ctrl_idle, .pm_active,
	.strobe_delay_pm, .master_adjust);

// *** dpt_ctrl_model.sv ***
// Controller-side partner: asks for power management, flags idle.
// Assumes the bench says when low power is wanted.
`timescale 1ns/1ps
module dpt_ctrl_model
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic want_pm,
	output logic pm_request,
	output logic ctrl_idle
);
	// Busy spells force the bank to hold its mode until idle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pm_request <= 1'b0;
			ctrl_idle <= 1'b1;
		end
		else
		begin
			pm_request <= want_pm;
			ctrl_idle <= ($urandom % 3) == 0;
		end
	end
endmodule : dpt_ctrl_model

// *** dpt_phy_timing_regs_test.sv ***
// Self-checking bench for the timing register bank.
// Assumes package, store, bank, checker and partner compiled first.
`timescale 1ns/1ps
module dpt_phy_timing_regs_test;
	import dpt_pkg::*;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic want_pm = 0;
	logic pce = 1;
	logic pready, pslverr, pm_request, ctrl_idle, pm_active, err;
	logic [31:0] prdata, strobe_delay_pm, rd;
	logic [3:0] data_phase_range, strobe_phase_range;
	logic [15:0] master_adjust, read_strobe_phase, write_data_phase;
	logic [11:0] dll_test_select;
	logic [1:0] dll_powerdown, dll_reset;
	logic [31:0] mdl [int];
	logic [31:0] msk [int];
	int fails = 0;
	int samples_checked = 0;
	always #2 pclk = ~pclk;
	dpt_ctrl_model u_ctrl (.pclk, .presetn, .want_pm, .pm_request, .ctrl_idle);
	dpt_phy_timing_regs dut (.pclk, .presetn, .pce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pready, .prdata, .pslverr, .pm_request, .ctrl_idle, .pm_active,
		.strobe_delay_pm, .data_phase_range, .strobe_phase_range, .master_adjust,
		.dll_test_select, .dll_powerdown, .dll_reset, .read_strobe_phase, .write_data_phase);
	// *****
	// Tasks
	// *****
	task automatic end_of_test;
		if (fails == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic init_mdl;
		for (int i = 0; i < NUM_CFG; i++)
		begin
			mdl[CFG_IDX[i]] = CFG_RST[i];
			msk[CFG_IDX[i]] = CFG_MASK[i];
		end
		for (int i = 0; i < NUM_SPARE; i++)
		begin
			mdl[SPARE_IDX[i]] = 32'h0;
			msk[SPARE_IDX[i]] = 32'hFFFFFFFF;
		end
	endtask : init_mdl
	// Leaves psel high so a following call runs back to back
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
		begin
			fails++;
			end_of_test();
		end
		rd = prdata;
		err = pslverr;
		penable <= 1'b0;
	endtask : apb
	task automatic idle;
		psel <= 1'b0;
		@(posedge pclk);
	endtask : idle
	task automatic wr(input int i, input logic [31:0] d);
		apb(1'b1, ADDR_W'(i * 4), d);
		if (msk.exists(i))
			mdl[i] = d & msk[i];
	endtask : wr
	task automatic rdc(input int i);
		apb(1'b0, ADDR_W'(i * 4), 32'h0);
		chk($sformatf("reg %h", i), msk.exists(i) ? mdl[i] : 32'h0, rd);
		chk("err", msk.exists(i) ? 1'b0 : 1'b1, err);
	endtask : rdc
	// Expected mode comes from the scenario, not from the design's own flag
	task automatic lanes(input logic p);
		int s;
		int b;
		s = p ? 16 : 0;
		b = p ? 31 : 15;
		chk("mode", p, pm_active);
		chk("dly", mdl[8'hD3], strobe_delay_pm);
		chk("dqr", mdl[8'hD6][s+:4], data_phase_range);
		chk("dsr", mdl[8'hD7][s+:4], strobe_phase_range);
		chk("adj", {mdl[8'hD9][s+:8], mdl[8'hD8][s+:8]}, master_adjust);
		chk("tst", {mdl[8'hD9][13:8], mdl[8'hD8][13:8]}, dll_test_select);
		chk("pd", {mdl[8'hD9][14], mdl[8'hD8][14]}, dll_powerdown);
		chk("rst", {mdl[8'hD9][b], mdl[8'hD8][b]}, dll_reset);
		chk("rdp", {mdl[8'hE1][s+:8], mdl[8'hE0][s+:8]}, read_strobe_phase);
		chk("wrp", {mdl[8'hE9][s+:8], mdl[8'hE8][s+:8]}, write_data_phase);
	endtask : lanes
	task automatic wait_pm(input logic v);
		int n;
		n = 0;
		while (pm_active !== v && n < 50)
		begin
			@(posedge pclk);
			n++;
		end
		chk("pm", v, pm_active);
		if (n >= 50)
			end_of_test();
		repeat (2) @(posedge pclk);
	endtask : wait_pm
	initial
	begin
		void'($urandom(88));
		init_mdl();
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 8'hD2; i < 8'hF5; i++)
			rdc(i);
		for (int i = 8'hD2; i < 8'hF5; i++)
			wr(i, $urandom);
		for (int i = 8'hD2; i < 8'hF5; i++)
			rdc(i);
		apb(1'b1, 12'h362, 32'hFFFFFFFF);
		chk("mis", 1'b1, err);
		apb(1'b0, 12'hF60, 32'h0);
		chk("alias", mdl[8'hD8], rd);
		idle();
		for (int c = 0; c < 4; c++)
		begin
			// Copies differ so that the mode switch shows on the range outputs
			wr(8'hD6, {12'h0, ~c[1:0], c[1:0], 12'h0, c[1:0], c[1:0]});
			wr(8'hD7, {12'h0, c[1:0], ~c[1:0], 12'h0, ~c[1:0], c[1:0]});
			idle();
			@(posedge pclk);
			lanes(1'b0);
		end
		want_pm <= 1'b1;
		wait_pm(1'b1);
		lanes(1'b1);
		want_pm <= 1'b0;
		wait_pm(1'b0);
		lanes(1'b0);
		// Clock enable low must hold the mode even with a request pending
		pce <= 1'b0;
		want_pm <= 1'b1;
		repeat (8) @(posedge pclk);
		chk("frz", 1'b0, pm_active);
		lanes(1'b0);
		pce <= 1'b1;
		want_pm <= 1'b0;
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		init_mdl();
		@(posedge pclk);
		lanes(1'b0);
		apb(1'b0, 12'h380, 32'h0);
		chk("rd0", 32'h00240024, rd);
		end_of_test();
	end
endmodule : dpt_phy_timing_regs_test
